// ---- hdl/ee_pkg.sv ----
// shared constants, opcodes, register map and lock decode for the eeprom engine
package ee_pkg;
    // instruction opcodes
    localparam logic [7:0] OP_SET_WEL = 8'h06;
    localparam logic [7:0] OP_CLR_WEL = 8'h04;
    localparam logic [7:0] OP_LOCK = 8'h01;
    localparam logic [7:0] OP_RD_STAT = 8'h05;
    localparam logic [7:0] OP_WRITE = 8'h02;
    localparam logic [7:0] OP_READ = 8'h03;
    // array geometry
    localparam int ADDR_W = 9;
    localparam int MEM_DEPTH = 512;
    localparam int PAGE_SIZE = 16;
    localparam int LOCK_W = 3;
    localparam logic [2:0] LOCK_RESET = 3'h0;
    // self-timed write length in clk cycles
    localparam int WR_BUSY_CYC = 240;
    localparam int BUSY_W = 8;
    // timing
    localparam int CLK_PERIOD_NS = 4;
    localparam int SCK_PERIOD_NS = 32;
    localparam int SCK_HALF_CYC = SCK_PERIOD_NS / (2 * CLK_PERIOD_NS);
    // controller register byte offsets
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_ADDR = 8'h04;
    localparam logic [7:0] REG_TXDATA = 8'h08;
    localparam logic [7:0] REG_CMD = 8'h0C;
    localparam logic [7:0] REG_STATUS = 8'h10;
    localparam logic [7:0] REG_RXDATA = 8'h14;
    // field positions and reset values
    localparam int CTRL_WP_BIT = 0;
    localparam logic CTRL_WP_RESET = 1'b1;
    localparam int CMD_OP_LSB = 0;
    localparam int CMD_LEN_LSB = 8;
    localparam int CMD_XBIT_LSB = 13;
    localparam int STATUS_BUSY_BIT = 0;

    // true when address a lies inside the range selected by lock code
    function automatic logic lock_hit(input logic [2:0] code, input logic [8:0] a);
        case (code)
            3'h1: lock_hit = (a[8:7] == 2'h0);
            3'h2: lock_hit = (a[8:7] == 2'h1);
            3'h3: lock_hit = (a[8:7] == 2'h2);
            3'h4: lock_hit = (a[8:7] == 2'h3);
            3'h5: lock_hit = !a[8];
            3'h6: lock_hit = (a[8:4] == 5'h00);
            3'h7: lock_hit = (a[8:4] == 5'h1F);
            default: lock_hit = 1'b0;
        endcase
    endfunction
endpackage

// ---- hdl/ee_spi_if.sv ----
// four-wire spi link plus write-protect between controller and eeprom
`timescale 1ns/100ps
interface ee_spi_if;
    logic sck;
    logic cs_n;
    logic mosi;
    logic wp_n;
    logic so_o;
    logic so_oe_n;
    wire miso;
    // released data-out shows the inverse of its last bit, so a late sample shows up
    assign miso = so_oe_n ? !so_o : so_o;
    modport dev(input sck, input cs_n, input mosi, input wp_n, output so_o, output so_oe_n);
    modport host(output sck, output cs_n, output mosi, output wp_n, input miso);
endinterface

// ---- hdl/ee_sync.sv ----
// two-flop synchroniser for a group of asynchronous pins
`timescale 1ns/100ps
module ee_sync #(
    parameter int W = 1
) (
    // system
    input wire logic clk,
    input wire logic rst,
    // pins
    input wire logic [W-1:0] din,
    output logic [W-1:0] dout
);
    logic [W-1:0] s1_r;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s1_r <= '0;
            dout <= '0;
        end else begin
            s1_r <= din;
            dout <= s1_r;
        end
    end
endmodule

// ---- hdl/ee_dev.sv ----
// eeprom end: spi command decode, array, page buffer, lock field
//
// Summary of operation
// R01: read: opcode, 16-bit address, low nine used
// R02: read streams bytes, address increments each byte
// R03: read address wraps from top to zero
// R04: chip select high ends read, releases output
// R05: status read returns lock field, upper zero
// R06: busy status read drives data-out high
// R07: status bit pointer advances while busy
// R08: latch set only if select rises after eight
// R09: writes need write latch set beforehand
// R10: write: opcode, address, data, select low
// R11: sixteen bytes per page, overflow wraps page
// R12: write starts only on byte boundary rise
// R13: lock opcode plus lock byte, then program
// R14: later lock byte replaces earlier one
// R15: powers up idle, needs select fall first
// R16: opcodes 06 set, 04 clear write latch
// R17: opcodes 03 read, 02 write decoded
// R18: lock codes select seven protected ranges
// R19: all fields shifted most significant first
// R20: write latch cleared when write completes
// R21: write-protect low blocks all nonvolatile writes
// R22: sample on sck rise, drive on fall
// R23: locked addresses readable, writes rejected
// R24: unknown opcode ignored, output stays released
//
// Decided for this implementation: the placing of the registers and the APB register port.
`timescale 1ns/100ps
module ee_dev (
    // system
    input wire logic clk,
    input wire logic rst,
    // spi link
    ee_spi_if.dev spi,
    // user side
    output logic busy,
    output logic write_latch,
    output logic [ee_pkg::LOCK_W-1:0] region_lock_field
);
    import ee_pkg::*;

    typedef enum {D_IDLE, D_OP, D_WEL, D_ADDR, D_RDATA, D_STAT, D_WDATA, D_LOCK, D_IGN} ee_dst_e;

    ee_dst_e st_r;
    ee_dst_e st_nxt;
    ee_dst_e op_st;
    logic [3:0] pins_s;
    logic sck_s;
    logic cs_s;
    logic si_s;
    logic wp_s;
    logic sck_d_r;
    logic cs_d_r;
    logic [6:0] sh_r;
    logic [2:0] bcnt_r;
    logic abyte_r;
    logic is_wr_r;
    logic [ADDR_W-1:0] addr_r;
    logic [2:0] obit_r;
    logic so_r;
    logic so_oe_n_r;
    logic wel_r;
    logic [BUSY_W-1:0] busy_cnt_r;
    logic [LOCK_W-1:0] lock_r;
    logic [LOCK_W-1:0] lock_new_r;
    logic got_r;
    logic [PAGE_SIZE-1:0] pmask_r;
    logic [7:0] pbuf [PAGE_SIZE];
    logic [7:0] mem [MEM_DEPTH];

    ee_sync #(.W(4)) u_sync (
        .clk(clk),
        .rst(rst),
        .din({spi.sck, spi.cs_n, spi.mosi, spi.wp_n}),
        .dout(pins_s)
    );

    assign sck_s = pins_s[3];
    assign cs_s = pins_s[2];
    assign si_s = pins_s[1];
    assign wp_s = pins_s[0];

    // edge detection on synchronised pins
    wire sck_rise = sck_s && !sck_d_r; // see R22
    wire sck_fall = !sck_s && sck_d_r; // see R22
    wire cs_rise = cs_s && !cs_d_r;
    wire cs_fall = !cs_s && cs_d_r; // see R15
    wire [7:0] in_byte = {sh_r, si_s}; // see R19
    wire byte_done = sck_rise && (bcnt_r == 3'h7);
    wire op_done = byte_done && (st_r == D_OP);
    wire [7:0] mem_q = mem[addr_r];
    wire [7:0] stat_byte = {5'h00, lock_r}; // see R05
    wire commit_wr = cs_rise && (st_r == D_WDATA) && (bcnt_r == 3'h0) && got_r && wp_s; // see R12
    wire commit_lk = cs_rise && (st_r == D_LOCK) && (bcnt_r == 3'h0) && got_r && wp_s; // see R13
    wire wel_done = (busy_cnt_r == BUSY_W'(1));

    assign busy = (busy_cnt_r != '0);
    assign write_latch = wel_r;
    assign region_lock_field = lock_r;
    assign spi.so_o = so_r;
    assign spi.so_oe_n = so_oe_n_r;

    // opcode decode; only status read is served while busy
    assign op_st = busy ? ((in_byte == OP_RD_STAT) ? D_STAT : D_IGN) :
                   (in_byte == OP_SET_WEL) ? D_WEL : // see R16
                   (in_byte == OP_READ) ? D_ADDR : // see R17
                   (in_byte == OP_WRITE && wel_r) ? D_ADDR : // see R09
                   (in_byte == OP_LOCK && wel_r) ? D_LOCK : // see R09
                   (in_byte == OP_RD_STAT) ? D_STAT :
                   D_IGN; // see R24

    always_comb begin
        st_nxt = st_r;
        if (cs_s) begin
            st_nxt = D_IDLE; // see R04
        end else if (cs_fall) begin
            st_nxt = D_OP;
        end else if (op_done) begin
            st_nxt = op_st;
        end else if (sck_rise && st_r == D_WEL) begin
            st_nxt = D_IGN; // see R08
        end else if (byte_done && st_r == D_ADDR && abyte_r) begin
            st_nxt = is_wr_r ? D_WDATA : D_RDATA; // see R01
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            st_r <= D_IDLE;
            sck_d_r <= 1'b0;
            cs_d_r <= 1'b0;
        end else begin
            st_r <= st_nxt;
            sck_d_r <= sck_s;
            cs_d_r <= cs_s;
        end
    end

    // shift, address and output datapath
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sh_r <= 7'h00;
            bcnt_r <= 3'h0;
            abyte_r <= 1'b0;
            is_wr_r <= 1'b0;
            addr_r <= '0;
            obit_r <= 3'h0;
            got_r <= 1'b0;
            pmask_r <= '0;
            lock_new_r <= LOCK_RESET;
            so_r <= 1'b0;
            so_oe_n_r <= 1'b1; // see R15
        end else if (cs_s || cs_fall) begin
            bcnt_r <= 3'h0;
            abyte_r <= 1'b0;
            obit_r <= 3'h0;
            got_r <= 1'b0;
            pmask_r <= '0;
            so_oe_n_r <= 1'b1; // see R04
        end else begin
            if (sck_rise) begin
                sh_r <= in_byte[6:0];
                bcnt_r <= bcnt_r + 3'h1;
            end
            if (op_done) begin
                is_wr_r <= (in_byte == OP_WRITE);
            end
            if (sck_rise && st_r == D_ADDR) begin
                addr_r <= {addr_r[ADDR_W-2:0], si_s}; // see R01
            end
            if (byte_done && st_r == D_ADDR) begin
                abyte_r <= 1'b1;
            end
            if (byte_done && st_r == D_WDATA) begin
                pmask_r[addr_r[3:0]] <= 1'b1;
                got_r <= 1'b1;
                addr_r <= {addr_r[ADDR_W-1:4], addr_r[3:0] + 4'h1}; // see R11
            end
            if (byte_done && st_r == D_LOCK) begin
                lock_new_r <= in_byte[LOCK_W-1:0]; // see R14
                got_r <= 1'b1;
            end
            if (sck_fall && st_r == D_RDATA) begin
                so_r <= mem_q[~obit_r]; // see R22
                so_oe_n_r <= 1'b0;
                obit_r <= obit_r + 3'h1;
                if (obit_r == 3'h7) begin
                    addr_r <= addr_r + ADDR_W'(1); // see R02 see R03
                end
            end
            if (sck_fall && st_r == D_STAT) begin
                so_r <= busy | stat_byte[~obit_r]; // see R06
                so_oe_n_r <= 1'b0;
                obit_r <= obit_r + 3'h1; // see R07
            end
        end
    end

    // write latch, busy timer and lock field
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wel_r <= 1'b0; // see R15
            busy_cnt_r <= '0;
            lock_r <= LOCK_RESET;
        end else begin
            if (cs_rise && st_r == D_WEL) begin
                wel_r <= 1'b1; // see R08
            end else if (op_done && !busy && in_byte == OP_CLR_WEL) begin
                wel_r <= 1'b0; // see R16
            end else if (wel_done) begin
                wel_r <= 1'b0; // see R20
            end
            if (commit_wr || commit_lk) begin
                busy_cnt_r <= BUSY_W'(WR_BUSY_CYC); // see R21
            end else if (busy) begin
                busy_cnt_r <= busy_cnt_r - BUSY_W'(1);
            end
            if (commit_lk) begin
                lock_r <= lock_new_r; // see R13
            end
        end
    end

    // page buffer and array, not reset
    always_ff @(posedge clk) begin
        if (!cs_s && byte_done && st_r == D_WDATA) begin
            pbuf[addr_r[3:0]] <= in_byte; // see R10
        end
        if (commit_wr) begin
            for (int i = 0; i < PAGE_SIZE; i++) begin
                if (pmask_r[i] && !lock_hit(lock_r, {addr_r[ADDR_W-1:4], 4'(i)})) begin
                    mem[{addr_r[ADDR_W-1:4], 4'(i)}] <= pbuf[i]; // see R18 see R23
                end
            end
        end
    end
endmodule

// ---- hdl/ee_host.sv ----
// controller end: apb registers drive an spi mode-0 master engine
`timescale 1ns/100ps
module ee_host (
    // system
    input wire logic clk,
    input wire logic rst,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // spi link
    ee_spi_if.host spi
);
    import ee_pkg::*;

    typedef enum {H_IDLE, H_SETUP, H_LOW, H_HIGH, H_HOLD, H_GAP} ee_hst_e;

    ee_hst_e st_r;
    ee_hst_e st_nxt;
    logic miso_s;
    logic wp_r;
    logic [ADDR_W-1:0] addr_reg_r;
    logic [31:0] tx_reg_r;
    logic [31:0] tx_sh_r;
    logic [31:0] rx_r;
    logic [23:0] hdr_r;
    logic [8:0] hdr_len_r;
    logic [8:0] tot_r;
    logic [8:0] b_r;
    logic [2:0] ph_r;
    logic sck_r;
    logic cs_n_r;
    logic mosi_r;

    ee_sync #(.W(1)) u_sync (
        .clk(clk),
        .rst(rst),
        .din(spi.miso),
        .dout(miso_s)
    );

    // register decode
    wire [7:0] off = paddr[7:0];
    wire hit_ctrl = (off == REG_CTRL);
    wire hit_addr = (off == REG_ADDR);
    wire hit_tx = (off == REG_TXDATA);
    wire hit_cmd = (off == REG_CMD);
    wire hit_stat = (off == REG_STATUS);
    wire hit_rx = (off == REG_RXDATA);
    wire mapped = (paddr[31:8] == 24'h000000) && (hit_ctrl || hit_addr || hit_tx ||
                  hit_cmd || hit_stat || hit_rx);
    wire wr_en = psel && penable && pwrite && mapped;
    wire eng_busy = (st_r != H_IDLE);
    wire start = wr_en && hit_cmd && !eng_busy;
    wire [7:0] cmd_op = pwdata[CMD_OP_LSB +: 8];
    wire [4:0] cmd_len = pwdata[CMD_LEN_LSB +: 5];
    wire [2:0] cmd_xbit = pwdata[CMD_XBIT_LSB +: 3];
    wire cmd_addr = (cmd_op == OP_READ) || (cmd_op == OP_WRITE);
    wire [8:0] cmd_hdr = cmd_addr ? 9'h018 : 9'h008;
    wire ph_done = (ph_r == 3'(SCK_HALF_CYC - 1));
    wire last_bit = (b_r == tot_r - 9'h001);
    wire in_hdr = (b_r < hdr_len_r);
    wire cur_bit = in_hdr ? hdr_r[23] : tx_sh_r[31];
    wire [31:0] rd_mux = hit_ctrl ? {31'h0, wp_r} :
                         hit_addr ? {23'h0, addr_reg_r} :
                         hit_tx ? tx_reg_r :
                         hit_stat ? {31'h0, eng_busy} :
                         hit_rx ? rx_r : 32'h0;

    assign pready = 1'b1;
    assign pslverr = psel && penable && !mapped;
    assign spi.sck = sck_r;
    assign spi.cs_n = cs_n_r;
    assign spi.mosi = mosi_r;
    assign spi.wp_n = wp_r;

    always_comb begin
        st_nxt = st_r;
        case (st_r)
            H_IDLE: st_nxt = start ? H_SETUP : H_IDLE;
            H_SETUP: st_nxt = ph_done ? H_LOW : H_SETUP;
            H_LOW: st_nxt = ph_done ? H_HIGH : H_LOW;
            H_HIGH: st_nxt = ph_done ? (last_bit ? H_HOLD : H_LOW) : H_HIGH;
            H_HOLD: st_nxt = ph_done ? H_GAP : H_HOLD;
            H_GAP: st_nxt = ph_done ? H_IDLE : H_GAP;
            default: st_nxt = H_IDLE;
        endcase
    end

    // apb registers
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wp_r <= CTRL_WP_RESET;
            addr_reg_r <= '0;
            tx_reg_r <= 32'h0;
            prdata <= 32'h0;
        end else begin
            if (psel && !penable) begin
                prdata <= rd_mux;
            end
            if (wr_en && hit_ctrl) begin
                wp_r <= pwdata[CTRL_WP_BIT];
            end
            if (wr_en && hit_addr) begin
                addr_reg_r <= pwdata[ADDR_W-1:0];
            end
            if (wr_en && hit_tx) begin
                tx_reg_r <= pwdata;
            end
        end
    end

    // spi engine, msb first, sck idles low
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            st_r <= H_IDLE;
            ph_r <= 3'h0;
            b_r <= 9'h000;
            tot_r <= 9'h008;
            hdr_len_r <= 9'h008;
            hdr_r <= 24'h0;
            tx_sh_r <= 32'h0;
            rx_r <= 32'h0;
            sck_r <= 1'b0;
            cs_n_r <= 1'b1;
            mosi_r <= 1'b0;
        end else begin
            st_r <= st_nxt;
            ph_r <= (st_nxt != st_r) ? 3'h0 : ph_r + 3'h1;
            sck_r <= (st_nxt == H_HIGH);
            cs_n_r <= (st_nxt == H_IDLE) || (st_nxt == H_GAP);
            if (start) begin
                b_r <= 9'h000;
                hdr_len_r <= cmd_hdr;
                tot_r <= cmd_hdr + {1'b0, cmd_len, 3'h0} + {6'h00, cmd_xbit};
                hdr_r <= cmd_addr ? {cmd_op, 7'h00, addr_reg_r} : {cmd_op, 16'h0000};
                tx_sh_r <= tx_reg_r;
            end
            if (st_r == H_SETUP || st_r == H_LOW) begin
                mosi_r <= cur_bit; // see R19
            end
            if (st_r == H_HIGH && ph_done) begin
                rx_r <= {rx_r[30:0], miso_s};
                b_r <= b_r + 9'h001;
                hdr_r <= {hdr_r[22:0], 1'b0};
                if (!in_hdr) begin
                    tx_sh_r <= {tx_sh_r[30:0], tx_sh_r[31]};
                end
            end
        end
    end
endmodule

// ---- bench/ee_props.sv ----
// concurrent checks on the link between controller and eeprom end
`timescale 1ns/100ps
module ee_props (
    // system
    input wire logic clk,
    input wire logic rst,
    // link
    input wire logic sck,
    input wire logic cs_n,
    input wire logic wp_n,
    input wire logic so_o,
    input wire logic so_oe_n,
    // device state
    input wire logic busy,
    input wire logic write_latch
);
    logic [7:0] busy_cnt_r;
    logic [7:0] busy_cnt_nxt;
    assign busy_cnt_nxt = busy ? busy_cnt_r + 8'h01 : 8'h00;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            busy_cnt_r <= 8'h00;
        end else begin
            busy_cnt_r <= busy_cnt_nxt;
        end
    end
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);
    AST_DESELECT_FLOAT: assert property (cs_n [*6] |-> so_oe_n)
        else $error("data-out still driven while deselected");
    AST_SO_ON_LOW: assert property (!so_oe_n && $past(!so_oe_n) && $changed(so_o) |-> !sck)
        else $error("data-out changed while sck high");
    AST_LATCH_CLEAR_DONE: assert property ($fell(busy) |-> ##[0:2] !write_latch)
        else $error("write latch not cleared after write cycle");
    AST_BUSY_LEN: assert property ($fell(busy) |-> busy_cnt_r >= 8'hEF && busy_cnt_r <= 8'hF1)
        else $error("write cycle length wrong");
    AST_COMMIT_DESELECT: assert property ($rose(busy) |-> cs_n && $past(cs_n))
        else $error("write started while selected");
    AST_LATCH_ON_DESELECT: assert property ($rose(write_latch) |-> cs_n)
        else $error("write latch set while selected");
    AST_COMMIT_NEEDS_LATCH: assert property ($rose(busy) |-> $past(write_latch))
        else $error("write started with latch clear");
    AST_COMMIT_NEEDS_WP: assert property ($rose(busy) |-> wp_n)
        else $error("write started while write-protect low");
    AST_BUSY_STAT_HIGH: assert property (busy && !so_oe_n |-> so_o)
        else $error("status read while busy did not show ones");
endmodule

// ---- bench/tb.sv ----
// self-checking bench: apb-driven controller talking to the eeprom end
`timescale 1ns/100ps
module tb;
    import ee_pkg::*;
    logic clk;
    logic rst;
    logic psel;
    logic penable;
    logic pwrite;
    logic [31:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic busy;
    logic write_latch;
    logic [LOCK_W-1:0] region_lock_field;
    logic [31:0] rd;
    logic err;
    logic [31:0] mosi_sh;
    int drv_cnt;
    int drv_mark;
    int fail_count;
    int n_checks;
    int cyc;
    ee_spi_if ifc();
    ee_dev u_ee_dev (.clk(clk), .rst(rst), .spi(ifc.dev), .busy(busy),
        .write_latch(write_latch), .region_lock_field(region_lock_field));
    ee_host u_ee_host (.clk(clk), .rst(rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .spi(ifc.host));
    ee_props u_props (.clk(clk), .rst(rst), .sck(ifc.sck), .cs_n(ifc.cs_n),
        .wp_n(ifc.wp_n), .so_o(ifc.so_o), .so_oe_n(ifc.so_oe_n), .busy(busy),
        .write_latch(write_latch));
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    // capture host data bits as the device samples them
    always @(posedge ifc.sck) begin
        mosi_sh <= {mosi_sh[30:0], ifc.mosi};
    end
    always @(posedge clk) begin
        if (ifc.so_oe_n === 1'b0) begin
            drv_cnt <= drv_cnt + 1;
        end
    end
    always @(posedge clk) begin
        cyc++;
        if (cyc == 80000) begin
            fail_count++;
            end_of_test();
        end
    end
    task automatic end_of_test();
        if (fail_count == 0 && n_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= {24'h000000, a};
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) @(posedge clk);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // one spi frame: header, len bytes plus extra bits, until the engine is idle
    task automatic fr(input logic [7:0] op, input logic [4:0] len, input logic [2:0] ext,
        input logic [8:0] a, input logic [31:0] tx);
        apb(1'b1, REG_ADDR, {23'h000000, a});
        apb(1'b1, REG_TXDATA, tx);
        apb(1'b1, REG_CMD, {16'h0000, ext, len, op});
        while (ifc.cs_n !== 1'b0) @(posedge clk);
        rd = 32'h00000001;
        while (rd[0] !== 1'b0) apb(1'b0, REG_STATUS, 32'h00000000);
    endtask
    // one frame, then wait until any write cycle it started is over
    task automatic go(input logic [7:0] op, input logic [4:0] len, input logic [2:0] ext,
        input logic [8:0] a, input logic [31:0] tx);
        fr(op, len, ext, a, tx);
        while (busy !== 1'b0) @(posedge clk);
    endtask
    task automatic wr1(input logic [8:0] a, input logic [7:0] b);
        go(OP_SET_WEL, 5'h00, 3'h0, 9'h000, 32'h00000000);
        go(OP_WRITE, 5'h01, 3'h0, a, {b, 24'h000000});
    endtask
    task automatic rdm(input logic [8:0] a, input logic [4:0] n, input logic [15:0] exp);
        go(OP_READ, n, 3'h0, a, 32'h00000000);
        apb(1'b0, REG_RXDATA, 32'h00000000);
        chk({16'h0000, (n == 5'h01) ? {8'h00, rd[7:0]} : rd[15:0]}, {16'h0000, exp});
        chk({31'h0, ifc.so_oe_n}, 32'h1);
    endtask
    initial begin
        rst = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 32'h00000000;
        pwdata = 32'h00000000;
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        chk({31'h0, write_latch}, 32'h0);
        apb(1'b0, REG_CTRL, 32'h00000000);
        chk(rd, 32'h00000001);
        apb(1'b0, 8'h18, 32'h00000000);
        chk({31'h0, err}, 32'h1);
        go(OP_SET_WEL, 5'h00, 3'h0, 9'h000, 32'h00000000);
        chk({24'h0, mosi_sh[7:0]}, 32'h06);
        chk({30'h0, ifc.sck, ifc.cs_n}, 32'h1);
        chk({31'h0, write_latch}, 32'h1);
        go(OP_CLR_WEL, 5'h00, 3'h0, 9'h000, 32'h00000000);
        chk({31'h0, write_latch}, 32'h0);
        go(OP_SET_WEL, 5'h00, 3'h1, 9'h000, 32'h00000000);
        chk({31'h0, write_latch}, 32'h0);
        wr1(9'h010, 8'h11);
        chk({31'h0, write_latch}, 32'h0);
        go(OP_WRITE, 5'h01, 3'h0, 9'h010, 32'h55000000);
        rdm(9'h010, 5'h01, 16'h0011);
        go(OP_SET_WEL, 5'h00, 3'h0, 9'h000, 32'h00000000);
        go(OP_WRITE, 5'h04, 3'h0, 9'h0FE, 32'hA1B2C3D4);
        rdm(9'h0F0, 5'h02, 16'hC3D4);
        rdm(9'h0FE, 5'h02, 16'hA1B2);
        wr1(9'h1FF, 8'h9A);
        wr1(9'h000, 8'h5B);
        rdm(9'h1FF, 5'h02, 16'h9A5B);
        wr1(9'h020, 8'h33);
        go(OP_SET_WEL, 5'h00, 3'h0, 9'h000, 32'h00000000);
        go(OP_WRITE, 5'h01, 3'h3, 9'h020, 32'hCC000000);
        rdm(9'h020, 5'h01, 16'h0033);
        wr1(9'h030, 8'h44);
        apb(1'b1, REG_CTRL, 32'h00000000);
        wr1(9'h030, 8'h66);
        apb(1'b1, REG_CTRL, 32'h00000001);
        rdm(9'h030, 5'h01, 16'h0044);
        wr1(9'h008, 8'h77);
        for (int c = 0; c < 8; c++) begin
            go(OP_SET_WEL, 5'h00, 3'h0, 9'h000, 32'h00000000);
            go(OP_LOCK, 5'h01, 3'h0, 9'h000, {5'h00, c[2:0], 24'h000000});
            chk({29'h0, region_lock_field}, c);
        end
        wr1(9'h1FF, 8'h00);
        rdm(9'h1FF, 5'h01, 16'h009A);
        go(OP_SET_WEL, 5'h00, 3'h0, 9'h000, 32'h00000000);
        fr(OP_LOCK, 5'h02, 3'h0, 9'h000, 32'h03060000);
        fr(OP_RD_STAT, 5'h01, 3'h0, 9'h000, 32'h00000000);
        apb(1'b0, REG_RXDATA, 32'h00000000);
        chk({24'h0, rd[7:0]}, 32'hFF);
        chk({31'h0, busy}, 32'h1);
        while (busy !== 1'b0) @(posedge clk);
        chk({29'h0, region_lock_field}, 32'h6);
        go(OP_RD_STAT, 5'h01, 3'h0, 9'h000, 32'h00000000);
        apb(1'b0, REG_RXDATA, 32'h00000000);
        chk({24'h0, rd[7:0]}, 32'h06);
        wr1(9'h008, 8'h88);
        rdm(9'h008, 5'h01, 16'h0077);
        wr1(9'h010, 8'h12);
        rdm(9'h010, 5'h01, 16'h0012);
        drv_mark = drv_cnt;
        go(8'hAB, 5'h01, 3'h0, 9'h000, 32'h00000000);
        chk(drv_cnt - drv_mark, 32'h0);
        end_of_test();
    end
endmodule
